// [logic/csr_config_select.sv]
// Top of the strap/configuration-select loader, serial register port and
// reference selector. Shared pins 8/9 are select inputs or open-drain serial lines.
// Assumes all pins are synchronous to i_clk and reset is held at power-up.
`timescale 1ns/10ps
module csr_config_select import csr_pkg::*; #(
	parameter int HOLD_CYC = SEL_HOLD_CYC,
	parameter logic [NV_WORDS*NV_W-1:0] NV_IMAGE = NV_IMAGE_DEFAULT
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_strap_out0_pin,
	output logic o_strap_out0_pin,
	output logic o_strap_out0_pin_oe,
	input wire logic i_shared_hi,
	input wire logic i_shared_lo,
	output logic o_shared_hi,
	output logic o_shared_hi_oe,
	input wire logic i_ref_select_pin,
	input wire logic i_crystal_ref_input,
	input wire logic i_diff_ref_input,
	output logic o_ref_clk,
	output logic o_ref_is_diff,
	output logic o_cfg_loaded,
	output logic [2:0] o_cfg_index,
	output logic o_serial_mode,
	output logic o_ss_en,
	output logic o_ss_down,
	output logic [4:0] o_ss_amount
);
	// All state lives in one packed struct so that reset, next-state and
	// register stay in step. The groups are:
	//  - loader: boot sequencing, strap copy, store index and the hold timer
	//  - image registers: the two live configuration bytes
	//  - reference mux: current selection and the registered output sample
	//  - serial port: line history, bit counter, shifter, pointer and ack drive
	// The hold timer runs once after reset and then stays done. A user who
	// shortens HOLD_CYC for bring-up must keep it above the filter settle
	// time, or the first followed change may see an unsettled select value.
	typedef struct packed {
		csr_ld_e ld;
		logic strap;
		logic loaded;
		logic [2:0] idx;
		logic [HOLD_W-1:0] hold_cnt;
		logic hold_done;
		logic [7:0] reg_dflt;
		logic [7:0] reg_ref;
		logic ref_sel;
		logic ref_out;
		csr_sp_e sp;
		logic scl_p;
		logic sda_p;
		logic [3:0] bits;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic rw;
		logic nack;
		logic sda_oe;
	} csr_top_s;

	csr_top_s st_q;
	csr_top_s st_d;
	logic [1:0] sel_flt;
	logic [NV_W-1:0] nv_rdata;
	logic [2:0] nv_addr;

	// Register read decode, shared by both serial read paths
	function automatic logic [7:0] reg_rd(input logic [7:0] ptr, input logic [7:0] r0,
		input logic [7:0] r13);
		if (ptr == REG_DEFAULT_SRC) begin
			reg_rd = r0;
		end else if (ptr == REG_REF_CTRL) begin
			reg_rd = r13;
		end else begin
			reg_rd = 8'h00;
		end
	endfunction : reg_rd

	// Clamp a spread amount code into the legal range
	function automatic logic [4:0] ss_clamp(input logic [4:0] amt);
		if (amt < SS_AMT_MIN) begin
			ss_clamp = SS_AMT_MIN;
		end else if (amt > SS_AMT_MAX) begin
			ss_clamp = SS_AMT_MAX;
		end else begin
			ss_clamp = amt;
		end
	endfunction : ss_clamp

	// Select pins filtered; only meaningful when the strap chose hardware select
	csr_sel_filter u_sel_filter (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_sel({i_shared_hi, i_shared_lo}),
		.o_sel(sel_flt)
	);

	csr_nv_store #(.IMAGE(NV_IMAGE)) u_nv_store (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_addr(nv_addr),
		.o_rdata(nv_rdata)
	);

	// Address held in the loader: boot reads word 0 first to learn the flag
	assign nv_addr = st_q.idx;

	always_comb begin
		logic scl_rise;
		logic scl_fall;
		logic sp_start;
		logic sp_stop;
		logic sp_on;
		logic want;
		logic [7:0] rd_byte;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		sp_start = 1'b0;
		sp_stop = 1'b0;
		sp_on = 1'b0;
		want = 1'b0;
		rd_byte = 8'h00;
		st_d = st_q;

		// Loader: capture strap once, then restore from the store
		unique case (st_q.ld)
			LD_BOOT: begin
				st_d.strap = i_strap_out0_pin;
				st_d.idx = 3'h0;
				st_d.ld = LD_BOOT_WAIT;
			end
			LD_BOOT_WAIT: begin
				// Word 0 now on the read port; its flag steers the boot choice.
				// The boot index uses the pin levels directly: the filter is
				// cleared by reset and has not settled two cycles after release.
				// The pins are tied to a supply or left low while the supply ramps,
				// so they are steady here and need no filtering at boot.
				if (st_q.strap) begin
					st_d.idx = {1'b0, i_shared_hi, i_shared_lo};
				end else if (nv_rdata[NV_W-1-(7-FLD_I2C_DEFAULT)]) begin
					st_d.idx = NV_IDX_I2C_DEF;
				end else begin
					st_d.idx = 3'h0;
				end
				st_d.ld = LD_READ;
			end
			LD_READ: begin
				st_d.ld = LD_WAIT;
			end
			LD_WAIT: begin
				// Two cycles from change to applied, far inside the 1 ms window
				st_d.reg_dflt = nv_rdata[15:8];
				st_d.reg_ref = nv_rdata[7:0];
				st_d.loaded = 1'b1;
				st_d.ld = LD_RUN;
			end
			LD_RUN: begin
				// Follow a filtered select change only when the image allows it
				want = st_q.strap && !st_q.reg_dflt[FLD_I2C_DEFAULT] && st_q.hold_done;
				if (want && ({1'b0, sel_flt} != st_q.idx)) begin
					st_d.idx = {1'b0, sel_flt};
					st_d.ld = LD_READ;
				end
			end
		endcase

		// Ten millisecond hold before select changes may be followed
		if (!st_q.hold_done) begin
			if (st_q.hold_cnt == HOLD_W'(HOLD_CYC - 1)) begin
				st_d.hold_done = 1'b1;
			end else begin
				st_d.hold_cnt = st_q.hold_cnt + HOLD_W'(1);
			end
		end

		// Reference mux with glitch-free hand-over: switch only while both sides low
		if (!st_q.reg_ref[FLD_SW_MODE_HI]) begin
			want = i_ref_select_pin ^ st_q.reg_ref[FLD_PRIM_SRC];
		end else begin
			want = st_q.ref_sel;
		end
		if (want != st_q.ref_sel && !st_q.ref_out &&
			!(want ? i_diff_ref_input : i_crystal_ref_input)) begin
			st_d.ref_sel = want;
		end
		st_d.ref_out = st_d.ref_sel ? i_diff_ref_input : i_crystal_ref_input;

		// Serial port: only with strap low and the restore finished.
		// Line roles: the lo pin is the serial clock, the hi pin the data.
		// Start and stop are recognised from the previous line levels, so a
		// data change while the clock is high always ends or restarts a frame.
		// The host must keep each clock half period at three cycles or more,
		// otherwise the one-cycle ack and data drive delay eats into setup.
		// Hazard: with the port off every frame is dropped without an ack, so
		// a host that starts talking before the load ends sees a missing ack.
		sp_on = st_q.loaded && !st_q.strap && st_q.ld == LD_RUN;
		st_d.scl_p = i_shared_lo;
		st_d.sda_p = i_shared_hi;
		scl_rise = i_shared_lo && !st_q.scl_p;
		scl_fall = !i_shared_lo && st_q.scl_p;
		sp_start = i_shared_lo && st_q.scl_p && st_q.sda_p && !i_shared_hi;
		sp_stop = i_shared_lo && st_q.scl_p && !st_q.sda_p && i_shared_hi;
		if (!sp_on || sp_stop) begin
			st_d.sp = SP_IDLE;
			st_d.sda_oe = 1'b0;
		end else if (sp_start) begin
			st_d.sp = SP_ADDR;
			st_d.bits = 4'h0;
			st_d.sda_oe = 1'b0;
		end else if (st_q.sp != SP_IDLE && scl_rise) begin
			if (st_q.sp == SP_RD && st_q.bits == 4'h8) begin
				st_d.nack = i_shared_hi;
			end else if (st_q.sp == SP_RD) begin
				st_d.shift = {st_q.shift[6:0], 1'b0};
			end else if (st_q.bits < 4'h8) begin
				st_d.shift = {st_q.shift[6:0], i_shared_hi};
			end
			if (st_q.bits < 4'h9) begin
				st_d.bits = st_q.bits + 4'h1;
			end
		end else if (st_q.sp != SP_IDLE && scl_fall) begin
			if (st_q.bits == 4'h8) begin
				// Byte complete: acknowledge unless we are the sender or the address is not ours
				unique case (st_q.sp)
					SP_ADDR: begin
						if (st_q.shift[7:1] == I2C_DEV_ADDR) begin
							st_d.rw = st_q.shift[0];
							st_d.sda_oe = 1'b1;
						end else begin
							st_d.sp = SP_IDLE;
						end
					end
					SP_PTR: begin
						st_d.ptr = st_q.shift;
						st_d.sda_oe = 1'b1;
					end
					SP_WR: begin
						if (st_q.ptr == REG_DEFAULT_SRC) begin
							st_d.reg_dflt = st_q.shift;
						end else if (st_q.ptr == REG_REF_CTRL) begin
							st_d.reg_ref = st_q.shift;
						end
						st_d.ptr = st_q.ptr + 8'h01;
						st_d.sda_oe = 1'b1;
					end
					SP_RD: begin
						st_d.sda_oe = 1'b0;
					end
					default: begin
						st_d.sp = SP_IDLE;
					end
				endcase
			end else if (st_q.bits == 4'h9) begin
				// Acknowledge slot over: move on to the next byte
				st_d.bits = 4'h0;
				st_d.sda_oe = 1'b0;
				rd_byte = reg_rd(st_q.ptr, st_q.reg_dflt, st_q.reg_ref);
				if (st_q.sp == SP_ADDR) begin
					st_d.sp = st_q.rw ? SP_RD : SP_PTR;
					if (st_q.rw) begin
						st_d.shift = rd_byte;
						st_d.sda_oe = !rd_byte[7];
					end
				end else if (st_q.sp == SP_PTR) begin
					st_d.sp = SP_WR;
				end else if (st_q.sp == SP_RD) begin
					if (st_q.nack) begin
						st_d.sp = SP_IDLE;
					end else begin
						rd_byte = reg_rd(st_q.ptr + 8'h01, st_q.reg_dflt, st_q.reg_ref);
						st_d.ptr = st_q.ptr + 8'h01;
						st_d.shift = rd_byte;
						st_d.sda_oe = !rd_byte[7];
					end
				end
			end else if (st_q.sp == SP_RD) begin
				st_d.sda_oe = !st_q.shift[7];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= '{ld: LD_BOOT, sp: SP_IDLE, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	// Strap pin turns into the reference output once sampled.
	// The pin is only driven after the capture edge, so the board resistor
	// alone sets the level that is latched.
	// The data line is open drain: the enable pulls it low, the pull-up
	// on the board gives the high level.
	assign o_strap_out0_pin = st_q.ref_out;
	assign o_strap_out0_pin_oe = st_q.ld != LD_BOOT;
	assign o_shared_hi = 1'b0; // Open drain: only ever pulls low
	assign o_shared_hi_oe = st_q.sda_oe;
	assign o_ref_clk = st_q.ref_out;
	assign o_ref_is_diff = st_q.ref_sel;
	assign o_cfg_loaded = st_q.loaded;
	assign o_cfg_index = st_q.idx;
	assign o_serial_mode = !st_q.strap;
	assign o_ss_en = st_q.reg_dflt[FLD_SS_EN];
	assign o_ss_down = st_q.reg_dflt[FLD_SS_DOWN];
	assign o_ss_amount = ss_clamp(st_q.reg_dflt[FLD_SS_AMT_LO +: FLD_SS_AMT_W]);
endmodule : csr_config_select

// [logic/csr_pkg.sv]
// Constants, register map, configuration image and state encodings for the
// strap/configuration-select loader and reference selector.
// Assumes a single 250 MHz clock and a synchronous, active-high reset at power-up.
// How it works
// - Strap pin level is sampled at power-up and held until next power-up.
// - Strap high: shared pins act as configuration select inputs hi and lo.
// - Strap low: shared pins act as serial data and clock lines.
// - After sampling, strap pin stops being input and drives reference clock out.
// - Strap high: load configuration 0..3 indexed by select pins; no serial access.
// - Strap low: serial only; boot loads serial defaults if flag set, else config 0.
// - Power-up configuration follows select levels seen at boot; open pin reads low.
// - Select changes followed only with strap high, flag clear, after 10 ms.
// - After a select change, new configuration loads and applies within 1 ms.
// - Manual mode: select pin 0 picks crystal input, 1 picks differential input.
// - Chosen reference is select pin XOR primary source bit.
// - Primary source bit is bit 1 of reference_source_control.
// - Spread settings: center 0.25 to 2.5 percent, down 0.5 to 5 percent.
// - Manual switchover active while upper switch mode bit is 0.
// - Reference change must not glitch the output.
// - Nonvolatile contents restored into registers before serial programming accepted.
package csr_pkg;
	// Clock and timing
	localparam int CLK_KHZ = 250000;
	localparam int SEL_HOLD_MS = 10;
	localparam int SEL_HOLD_CYC = SEL_HOLD_MS * CLK_KHZ;
	localparam int LOAD_LIMIT_MS = 1;
	localparam int LOAD_LIMIT_CYC = LOAD_LIMIT_MS * CLK_KHZ;
	localparam int SEL_STABLE_CYC = 16;
	localparam int HOLD_W = 22;

	// Register offsets and fields
	localparam logic [7:0] REG_DEFAULT_SRC = 8'h00;
	localparam logic [7:0] REG_REF_CTRL = 8'h13;
	localparam int FLD_I2C_DEFAULT = 7;
	localparam int FLD_SS_EN = 6;
	localparam int FLD_SS_DOWN = 5;
	localparam int FLD_SS_AMT_LO = 0;
	localparam int FLD_SS_AMT_W = 5;
	localparam int FLD_PRIM_SRC = 1;
	localparam int FLD_SW_MODE_HI = 7;
	localparam int FLD_SW_MODE_LO = 6;

	// Spread amount codes: center in 0.25 % steps, down in 0.5 % steps
	localparam logic [4:0] SS_AMT_MIN = 5'h01;
	localparam logic [4:0] SS_AMT_MAX = 5'h0A;

	// Serial port address, arbitrary default
	localparam logic [6:0] I2C_DEV_ADDR = 7'h6A;

	// Nonvolatile image: five words of {reg 0x00, reg 0x13}; index 4 = serial defaults
	localparam int NV_WORDS = 5;
	localparam int NV_W = 16;
	localparam logic [2:0] NV_IDX_I2C_DEF = 3'h4;
	localparam logic [NV_WORDS*NV_W-1:0] NV_IMAGE_DEFAULT = 80'h0000_4203_4102_4001_0000;

	typedef enum logic [4:0] {
		LD_BOOT = 5'b00001,
		LD_BOOT_WAIT = 5'b00010,
		LD_READ = 5'b00100,
		LD_WAIT = 5'b01000,
		LD_RUN = 5'b10000
	} csr_ld_e;

	typedef enum logic [4:0] {
		SP_IDLE = 5'b00001,
		SP_ADDR = 5'b00010,
		SP_PTR = 5'b00100,
		SP_WR = 5'b01000,
		SP_RD = 5'b10000
	} csr_sp_e;
endpackage : csr_pkg

// [logic/csr_nv_store.sv]
// Nonvolatile configuration store: five words, registered read data.
// Assumes contents are fixed at build time through the image parameter.
`timescale 1ns/10ps
module csr_nv_store import csr_pkg::*; #(
	parameter logic [NV_WORDS*NV_W-1:0] IMAGE = NV_IMAGE_DEFAULT
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [2:0] i_addr,
	output logic [NV_W-1:0] o_rdata
);
	logic [NV_W-1:0] rdata_q;

	// One-cycle read latency; out-of-range index reads zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_q <= '0;
		end else if (int'(i_addr) < NV_WORDS) begin
			rdata_q <= IMAGE[i_addr*NV_W +: NV_W];
		end else begin
			rdata_q <= '0;
		end
	end

	assign o_rdata = rdata_q;
endmodule : csr_nv_store

// [logic/csr_sel_filter.sv]
// Two-bit select synchroniser with stability filter.
// Assumes inputs may change at any time; output moves only after a stable run.
`timescale 1ns/10ps
module csr_sel_filter import csr_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [1:0] i_sel,
	output logic [1:0] o_sel
);
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
		logic [1:0] cand;
		logic [4:0] cnt;
		logic [1:0] sel;
	} csr_flt_s;

	csr_flt_s st_q;
	csr_flt_s st_d;

	// Count how long the synchronised level has matched the candidate
	always_comb begin
		st_d = st_q;
		st_d.meta = i_sel;
		st_d.sync = st_q.meta;
		if (st_q.sync != st_q.cand) begin
			st_d.cand = st_q.sync;
			st_d.cnt = '0;
		end else if (st_q.cnt < 5'(SEL_STABLE_CYC)) begin
			st_d.cnt = st_q.cnt + 5'h01;
		end else begin
			st_d.sel = st_q.cand;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_sel = st_q.sel;
endmodule : csr_sel_filter

// [tb/csr_cs_asserts.sv]
// Checker for the strap loader and reference selector, bound to its top.
// Assumes only the top ports and a synchronous power-up reset.
`timescale 1ns/10ps
module csr_cs_asserts import csr_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_crystal_ref_input,
	input wire logic i_diff_ref_input,
	input wire logic o_strap_out0_pin,
	input wire logic o_strap_out0_pin_oe,
	input wire logic o_shared_hi_oe,
	input wire logic o_ref_clk,
	input wire logic o_ref_is_diff,
	input wire logic o_cfg_loaded,
	input wire logic [2:0] o_cfg_index,
	input wire logic o_serial_mode,
	input wire logic [4:0] o_ss_amount
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Pin turns to an output right after the strap capture
	a_strap_oe_rise: assert property ($fell(i_rst) |-> ##[1:2] o_strap_out0_pin_oe)
		else $error("strap pin not driven after boot");
	a_strap_oe_hold: assert property (o_strap_out0_pin_oe |=> o_strap_out0_pin_oe)
		else $error("strap pin released");
	// Role of the shared pins may not move once latched
	a_mode_held: assert property ($past(o_strap_out0_pin_oe) |-> $stable(o_serial_mode))
		else $error("pin role changed");
	a_load_time: assert property ($fell(i_rst) |-> ##[3:5] o_cfg_loaded)
		else $error("boot load late");
	a_hw_index: assert property (o_cfg_loaded && !o_serial_mode |-> o_cfg_index <= 3'h3)
		else $error("bad hardware index");
	a_serial_index: assert property (o_cfg_loaded && o_serial_mode |->
		o_cfg_index inside {3'h0, 3'h4})
		else $error("bad serial index");
	a_out0_copy: assert property (o_strap_out0_pin_oe |-> o_strap_out0_pin == o_ref_clk)
		else $error("reference output pin wrong");
	// Output follows the chosen input one cycle late
	a_ref_follow: assert property (o_cfg_loaded && $stable(o_ref_is_diff) |->
		o_ref_clk == (o_ref_is_diff ? $past(i_diff_ref_input) : $past(i_crystal_ref_input)))
		else $error("reference output wrong source");
	// Switching only while low avoids a runt pulse
	a_switch_low: assert property (o_cfg_loaded && $changed(o_ref_is_diff) |-> !$past(o_ref_clk))
		else $error("switch while output high");
	a_ss_range: assert property (o_ss_amount inside {[5'h01:5'h0A]})
		else $error("spread amount out of range");
	a_no_serial_hw: assert property (!o_serial_mode |-> !o_shared_hi_oe)
		else $error("data line driven in select mode");
	c_hw_boot: cover property (o_cfg_loaded && !o_serial_mode && o_cfg_index == 3'h3);
	c_serial: cover property (o_cfg_loaded && o_serial_mode);
	c_ack: cover property ($rose(o_shared_hi_oe));
endmodule : csr_cs_asserts

bind csr_config_select csr_cs_asserts chk_u (.*);

// [tb/csr_board_model.sv]
// Board model: strap resistor, select driver, serial line pull-ups, references.
// Assumes the bench drives select and host levels; lines resolve here.
`timescale 1ns/10ps
module csr_board_model (
	input wire logic i_clk,
	input wire logic i_strap_pull,
	input wire logic i_serial,
	input wire logic [1:0] i_sel,
	input wire logic i_host_sda,
	input wire logic i_host_scl,
	input wire logic i_dev_pin,
	input wire logic i_dev_pin_oe,
	input wire logic i_dev_sda_oe,
	output logic o_strap_line,
	output logic o_hi_line,
	output logic o_lo_line,
	output logic o_xtal,
	output logic o_diff
);
	logic [3:0] cnt_q = 4'h0;
	// Resistor level shows until the device drives the pin
	assign o_strap_line = i_dev_pin_oe ? i_dev_pin : i_strap_pull;
	// Pull-ups on both lines; the device can only pull data low
	assign o_hi_line = i_serial ? (i_host_sda & ~i_dev_sda_oe) : i_sel[1];
	assign o_lo_line = i_serial ? i_host_scl : i_sel[0];
	// Two different rates so a wrong pick shows
	always @(posedge i_clk) begin
		cnt_q <= cnt_q + 4'h1;
	end
	assign o_xtal = cnt_q[1];
	assign o_diff = cnt_q[3];
endmodule : csr_board_model

// [tb/csr_config_select_tb.sv]
// Bench for the strap loader, select following, serial port and reference mux.
// Assumes the board model resolves pins; hold count shortened to 200 cycles.
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end
module csr_config_select_tb import csr_pkg::*;;
	logic i_clk, i_rst, i_ref_select_pin, strap_pull, serial, host_sda, host_scl, ack;
	logic [1:0] sel;
	logic i_strap_out0_pin, i_shared_hi, i_shared_lo, i_crystal_ref_input, i_diff_ref_input;
	logic o_strap_out0_pin, o_strap_out0_pin_oe, o_shared_hi, o_shared_hi_oe, o_ref_clk;
	logic o_ref_is_diff, o_cfg_loaded, o_serial_mode, o_ss_en, o_ss_down;
	logic [2:0] o_cfg_index;
	logic [4:0] o_ss_amount;
	logic [7:0] e;
	int num_errors = 0;
	int tests_run = 0;
	localparam logic [7:0] EXP00 [4] = '{8'h00, 8'h40, 8'h41, 8'h42};
	csr_config_select #(.HOLD_CYC(200)) dut_u (.*);
	csr_board_model board_u (.i_clk(i_clk), .i_strap_pull(strap_pull), .i_serial(serial),
		.i_sel(sel), .i_host_sda(host_sda), .i_host_scl(host_scl),
		.i_dev_pin(o_strap_out0_pin), .i_dev_pin_oe(o_strap_out0_pin_oe),
		.i_dev_sda_oe(o_shared_hi_oe), .o_strap_line(i_strap_out0_pin),
		.o_hi_line(i_shared_hi), .o_lo_line(i_shared_lo),
		.o_xtal(i_crystal_ref_input), .o_diff(i_diff_ref_input));
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	// Select pins held steady through reset so the filter settles
	task automatic boot(input logic s, input logic [1:0] v);
		strap_pull = s;
		serial = ~s;
		sel = v;
		i_rst = 1'b1;
		tick(20);
		i_rst = 1'b0;
		tick(30);
	endtask : boot
	// Data moves mid-low so no false start or stop is seen
	task automatic i2c_bit(input logic b, output logic r);
		tick(2);
		host_sda = b;
		tick(2);
		host_scl = 1'b1;
		tick(4);
		r = i_shared_hi;
		host_scl = 1'b0;
	endtask : i2c_bit
	task automatic i2c_byte(input logic [7:0] d, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) i2c_bit(d[i], r);
		i2c_bit(1'b1, a);
	endtask : i2c_byte
	// Host releases data so the device can drive each bit, then nacks
	task automatic i2c_read(output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) i2c_bit(1'b1, q[i]);
		i2c_bit(1'b1, a);
	endtask : i2c_read
	task automatic i2c_start;
		tick(4);
		host_sda = 1'b0;
		tick(4);
		host_scl = 1'b0;
	endtask : i2c_start
	task automatic i2c_stop;
		tick(2);
		host_sda = 1'b0;
		tick(2);
		host_scl = 1'b1;
		tick(4);
		host_sda = 1'b1;
		tick(4);
	endtask : i2c_stop
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	initial begin
		#80000;
		num_errors++;
		final_report();
	end
	initial begin
		i_rst = 1'b1;
		i_ref_select_pin = 1'b0;
		host_sda = 1'b1;
		host_scl = 1'b1;
		strap_pull = 1'b1;
		serial = 1'b0;
		sel = 2'b00;
		// Every hardware-selected configuration 0..3, then both select-pin levels
		for (int k = 0; k < 4; k++) begin
			boot(1'b1, k[1:0]);
			e = EXP00[k];
			`CHK("index", k[2:0], o_cfg_index)
			`CHK("mode", 1'b0, o_serial_mode)
			`CHK("pin oe", 1'b1, o_strap_out0_pin_oe)
			`CHK("loaded", 1'b1, o_cfg_loaded)
			`CHK("ss en", e[6], o_ss_en)
			`CHK("ss down", e[5], o_ss_down)
			`CHK("ss amt", (e[4:0] == 5'h00) ? 5'h01 : e[4:0], o_ss_amount)
			for (int j = 0; j < 2; j++) begin
				i_ref_select_pin = j[0];
				tick(40);
				`CHK("ref", j[0] ^ k[1], o_ref_is_diff)
			end
		end
		// Early change ignored, later single-pin change followed
		boot(1'b1, 2'b10);
		sel = 2'b11;
		tick(40);
		`CHK("early index", 3'h2, o_cfg_index)
		sel = 2'b10;
		tick(200);
		sel = 2'b11;
		tick(40);
		`CHK("late index", 3'h3, o_cfg_index)
		`CHK("late amt", 5'h02, o_ss_amount)
		// Serial mode: boot to configuration 0, then flip polarity
		boot(1'b0, 2'b11);
		`CHK("serial mode", 1'b1, o_serial_mode)
		`CHK("serial index", 3'h0, o_cfg_index)
		i_ref_select_pin = 1'b0;
		i2c_start();
		i2c_byte(8'hD4, ack);
		`CHK("addr ack", 1'b0, ack)
		i2c_byte(8'h13, ack);
		`CHK("ptr ack", 1'b0, ack)
		i2c_byte(8'h02, ack);
		`CHK("data ack", 1'b0, ack)
		i2c_stop();
		tick(40);
		`CHK("inverted ref", 1'b1, o_ref_is_diff)
		i2c_start();
		i2c_byte(8'hA0, ack);
		`CHK("foreign addr", 1'b1, ack)
		i2c_stop();
		// Set the pointer, then read the register back
		i2c_start();
		i2c_byte(8'hD4, ack);
		i2c_byte(8'h13, ack);
		`CHK("rd ptr ack", 1'b0, ack)
		i2c_stop();
		i2c_start();
		i2c_byte(8'hD5, ack);
		`CHK("rd addr ack", 1'b0, ack)
		i2c_read(e);
		`CHK("readback", 8'h02, e)
		`CHK("sda level", 1'b0, o_shared_hi)
		i2c_stop();
		final_report();
	end
endmodule : csr_config_select_tb
